/* rtl/fepcs_mii_path.sv */
// fepcs_mii_path: 100 Mb line coding, alignment and MII/RMII data path
// assumes line levels arrive one symbol per core cycle; pins are async
`timescale 1ns/100ps
// Summary of operation
// RL1 - transmit scrambler seed comes from the strapped PHY address
// RL2 - 5-bit groups are shifted out serially and turned into NRZI
// RL3 - MLT-3 steps to the next level on a one, holds on a zero
// RL4 - received MLT-3 levels are turned back into NRZI, then serial bits
// RL5 - descrambler inverts the scrambler and regroups bits into 5-bit words
// RL6 - descrambler key trains on idle, then stays locked until resync or lost signal detect
// RL7 - no idle within the 40 us window aborts reception and resyncs
// RL8 - J-K pair sets group alignment, kept until the next frame start
// RL9 - start delimiter gives two 0101 nibbles, data groups give nibbles
// RL10 - receive valid rises with the first preamble nibble
// RL11 - T-R or two idles end carrier and valid, without data nibbles
// RL12 - link failure or lost signal detect also ends valid
// RL13 - unexpected group inside a frame raises receive error
// RL14 - bad start delimiter gives error, nibble 1110, valid low
// RL15 - MII receive nibbles change on the falling receive clock edge
// RL16 - receive clock follows data with signal, else the reference; the code follows data only at 100 Mb and uses the reference at 10 Mb
// RL17 - RMII receive dibits change every reference clock
// RL18 - 10 Mb transmit nibbles captured on rising link clock with enable
// RL19 - RMII MAC presents a dibit every reference period while enabled
// RL20 - transmit data is ignored while transmit enable is low
// RL21 - 10 Mb half duplex echoes transmit data, no collision, heartbeat; the code echoes in MII mode only, not in RMII
// RL22 - 11000 then 10001 start a frame; J without K is an error
// RL23 - 01101 then 00111 end carrier only in that order
// RL24 - 11111 is idle and is sent between frames
// RL25 - invalid groups during receive valid raise receive error
// RL26 - key sequence uses x^11 + x^9 + 1 per serial bit
module fepcs_mii_path (
	input wire logic ref_clk_i, // 50 MHz core and RMII clock
	input wire logic rst_n_i, // async reset, low
	input wire logic link_clk_i, // MAC transmit clock, sampled
	input wire logic tx_en_i, // MAC transmit enable
	input wire logic [3:0] txd_i, // MAC transmit data
	input wire logic [1:0] rx_level_i, // recovered MLT-3 level
	input wire logic signal_detect_flag_i, // line signal present
	input wire logic link_fail_i, // link test failure
	input wire logic rmii_mode_i, // 1 = RMII, 0 = MII
	input wire logic speed_100_i, // 1 = 100 Mb, 0 = 10 Mb
	input wire logic half_duplex_i, // half duplex operation
	input wire logic [4:0] phy_address_setting_i, // PHY address strap
	output logic [1:0] tx_level_o, // MLT-3 level to the driver
	output logic [3:0] rxd_o, // receive data to MAC
	output logic rx_dv_o, // receive data valid
	output logic rx_er_o, // receive error
	output logic crs_o, // carrier sense
	output logic col_o, // collision / heartbeat
	output logic rx_clk_o // MII receive clock
);
	import fepcs_pkg::*;

	typedef enum logic [1:0] {TX_IDLE, TX_K, TX_DATA, TX_R} fepcs_txst_t;
	typedef enum logic [1:0] {RX_HUNT, RX_K, RX_FRAME} fepcs_rxst_t;

	fepcs_pins_t pin_a;
	fepcs_pins_t pin;
	logic [1:0] strap_cnt;
	logic link_q;
	logic link_rise;
	logic txen_q;

	// two-flop capture of every asynchronous pin
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_a <= '0;
			pin <= '0;
		end else begin
			pin_a <= fepcs_pins_t'({link_clk_i, tx_en_i, txd_i, rx_level_i,
				signal_detect_flag_i, link_fail_i, rmii_mode_i, speed_100_i,
				half_duplex_i, phy_address_setting_i});
			pin <= pin_a;
		end
	end

	// strap taken once the synchroniser has filled after release
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			strap_cnt <= '0;
		end else if (strap_cnt != '1) begin
			// parks at all ones: a wrap would reseed the scrambler mid-stream
			strap_cnt <= strap_cnt + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			link_q <= 1'b0;
			txen_q <= 1'b0;
		end else begin
			link_q <= pin.link_clk;
			txen_q <= pin.txen;
		end
	end
	assign link_rise = pin.link_clk & ~link_q;

	// transmit nibble capture
	logic [3:0] nib;
	logic nib_stb;
	logic dib_half;
	logic [1:0] dib_lo;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			nib <= '0;
			nib_stb <= 1'b0;
			dib_half <= 1'b0;
			dib_lo <= '0;
		end else begin
			nib_stb <= 1'b0;
			if (pin.rmii) begin
				if (!pin.txen) begin
					dib_half <= 1'b0; // RL20
				end else if (!dib_half) begin
					dib_lo <= pin.txd[1:0]; // RL19
					dib_half <= 1'b1;
				end else begin
					nib <= {pin.txd[1:0], dib_lo};
					nib_stb <= 1'b1;
					dib_half <= 1'b0;
				end
			end else if (link_rise && pin.txen) begin
				nib <= pin.txd; // RL18
				nib_stb <= 1'b1;
			end
		end
	end

	// 100 Mb transmit: 4B/5B, scrambler, NRZI, MLT-3
	fepcs_txst_t tx_st;
	logic [2:0] tx_ph;
	logic tx_slot;
	logic [4:0] tx_sh;
	logic [3:0] hold;
	logic hold_v;
	logic [LFSR_W-1:0] tx_lfsr;
	logic tx_key;
	logic tx_nrzi;
	logic tx_nrzi_q;
	logic mlt_up;

	assign tx_slot = (tx_ph == PHASE_LAST);
	assign tx_key = tx_lfsr[TAP_A] ^ tx_lfsr[TAP_B];

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold <= '0;
			hold_v <= 1'b0;
		end else begin
			if (tx_slot && tx_st == TX_DATA && hold_v) begin
				hold_v <= 1'b0;
			end
			if (nib_stb) begin
				hold <= nib;
				hold_v <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_ph <= '0;
			tx_st <= TX_IDLE;
			tx_sh <= CG_IDLE;
		end else begin
			tx_ph <= tx_slot ? '0 : tx_ph + 1'b1;
			if (!tx_slot) begin
				tx_sh <= {tx_sh[3:0], 1'b0}; // RL2
			end else begin
				case (tx_st)
					TX_IDLE: begin
						if (pin.txen && pin.speed100) begin
							tx_sh <= CG_J;
							tx_st <= TX_K;
						end else begin
							tx_sh <= CG_IDLE; // RL24
						end
					end
					TX_K: begin
						tx_sh <= CG_K;
						tx_st <= TX_DATA;
					end
					TX_DATA: begin
						if (hold_v) begin
							tx_sh <= fepcs_enc5(hold);
						end else if (!pin.txen) begin
							tx_sh <= CG_T;
							tx_st <= TX_R;
						end else begin
							tx_sh <= CG_H; // underrun
						end
					end
					TX_R: begin
						tx_sh <= CG_R;
						tx_st <= TX_IDLE;
					end
					default: tx_st <= TX_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_lfsr <= '1;
			tx_nrzi <= 1'b0;
			tx_nrzi_q <= 1'b0;
		end else if (strap_cnt == STRAP_CYC) begin
			tx_lfsr <= {SEED_TOP, pin.phy_address_setting, SEED_LOW}; // RL1
		end else begin
			tx_lfsr <= {tx_lfsr[LFSR_W-2:0], tx_key}; // RL26
			tx_nrzi <= tx_nrzi ^ tx_sh[4] ^ tx_key; // RL2
			tx_nrzi_q <= tx_nrzi;
		end
	end

	// walks 0, +, 0, - on each NRZI transition
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_level_o <= LVL_ZERO;
			mlt_up <= 1'b1;
		end else if (!pin.speed100) begin
			tx_level_o <= LVL_ZERO;
		end else if (tx_nrzi ^ tx_nrzi_q) begin
			if (tx_level_o == LVL_ZERO) begin
				tx_level_o <= mlt_up ? LVL_POS : LVL_NEG; // RL3
				mlt_up <= ~mlt_up;
			end else begin
				tx_level_o <= LVL_ZERO; // RL3
			end
		end
	end

	// 100 Mb receive: MLT-3 to NRZI, descrambler
	logic [1:0] lvl_q;
	logic rx_nrzi;
	logic rx_nrzi_q;
	logic rbit;
	logic [LFSR_W-1:0] rx_lfsr;
	logic pred;
	logic dbit;
	logic locked;
	logic [SYNC_W-1:0] match_cnt;
	logic [WIN_W-1:0] win_cnt;
	logic resync;
	logic [9:0] dsh;
	logic idle_seen;

	assign rbit = rx_nrzi ^ rx_nrzi_q;
	assign pred = rx_lfsr[TAP_A] ^ rx_lfsr[TAP_B];
	assign dbit = rbit ^ pred;
	assign idle_seen = (dsh == '1);
	assign resync = (win_cnt == WIN_W'(IDLE_WINDOW_CYC - 1));

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lvl_q <= LVL_ZERO;
			rx_nrzi <= 1'b0;
			rx_nrzi_q <= 1'b0;
		end else begin
			lvl_q <= pin.level;
			rx_nrzi <= rx_nrzi ^ (pin.level != lvl_q); // RL4
			rx_nrzi_q <= rx_nrzi;
		end
	end

	// idle is all ones before scrambling, so the key is the inverted line bit
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_lfsr <= '0;
			locked <= 1'b0;
			match_cnt <= '0;
		end else if (!locked) begin
			rx_lfsr <= {rx_lfsr[LFSR_W-2:0], ~rbit}; // RL6
			if (~rbit == pred) begin
				match_cnt <= match_cnt + 1'b1;
			end else begin
				match_cnt <= '0;
			end
			if (match_cnt == SYNC_W'(SYNC_BITS - 1)) begin
				locked <= 1'b1; // RL6
			end
		end else begin
			rx_lfsr <= {rx_lfsr[LFSR_W-2:0], pred}; // RL26
			if (resync || !pin.signal_detect_flag) begin
				locked <= 1'b0; // RL7
				match_cnt <= '0;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			win_cnt <= '0;
			dsh <= '0;
		end else begin
			dsh <= {dsh[8:0], dbit}; // RL5
			if (!locked || idle_seen) begin
				win_cnt <= '0;
			end else begin
				win_cnt <= win_cnt + 1'b1; // RL7
			end
		end
	end

	// alignment and 5B/4B decode
	fepcs_rxst_t rx_st;
	logic [2:0] rx_ph;
	logic rx_slot;
	logic [4:0] grp;
	logic [4:0] dec;
	logic t_seen;
	logic idle_prev;
	logic pend;
	logic crs100;
	logic ovr;
	logic abort;
	logic push100;
	fepcs_rxw_t pw100;

	assign rx_slot = (rx_ph == PHASE_LAST);
	assign grp = dsh[4:0];
	assign dec = fepcs_dec5(grp);
	assign abort = !pin.signal_detect_flag || pin.link_fail || resync || !pin.speed100;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_st <= RX_HUNT;
			rx_ph <= '0;
			t_seen <= 1'b0;
			idle_prev <= 1'b0;
			pend <= 1'b0;
			crs100 <= 1'b0;
			push100 <= 1'b0;
			pw100 <= '0;
		end else begin
			rx_ph <= rx_slot ? '0 : rx_ph + 1'b1;
			push100 <= 1'b0;
			pend <= 1'b0;
			if (abort) begin
				rx_st <= RX_HUNT; // RL12
				crs100 <= 1'b0;
			end else begin
				case (rx_st)
					RX_HUNT: begin
						if (locked && dsh == {CG_IDLE, CG_J}) begin
							rx_ph <= '0; // RL8
							rx_st <= RX_K;
							crs100 <= 1'b1;
						end
					end
					RX_K: begin
						if (rx_slot && grp == CG_K) begin
							push100 <= 1'b1; // RL10
							pw100 <= '{data: NIB_PRE, dv: 1'b1, er: 1'b0}; // RL9
							pend <= 1'b1;
							t_seen <= 1'b0;
							idle_prev <= 1'b0;
							rx_st <= RX_FRAME; // RL22
						end else if (rx_slot) begin
							push100 <= 1'b1;
							pw100 <= '{data: NIB_BAD_SSD, dv: 1'b0, er: 1'b1}; // RL14
							crs100 <= 1'b0;
							rx_st <= RX_HUNT; // RL22
						end
					end
					RX_FRAME: begin
						if (pend) begin
							push100 <= 1'b1;
							pw100 <= '{data: NIB_PRE, dv: 1'b1, er: 1'b0}; // RL9
						end
						if (rx_slot) begin
							idle_prev <= (grp == CG_IDLE);
							t_seen <= (grp == CG_T);
							if ((t_seen && grp == CG_R) || (idle_prev && grp == CG_IDLE)) begin
								crs100 <= 1'b0; // RL11 RL23
								rx_st <= RX_HUNT;
							end else if (grp != CG_T && grp != CG_IDLE) begin
								push100 <= 1'b1; // RL9
								pw100 <= '{data: dec[3:0], dv: 1'b1,
									er: ~dec[4] | t_seen}; // RL13 RL25
							end
						end
					end
					default: rx_st <= RX_HUNT;
				endcase
			end
		end
	end

	// 10 Mb half duplex echo and heartbeat
	logic push10;
	logic [SQE_W-1:0] sqe_cnt;
	logic loop_on;

	assign loop_on = !pin.speed100 && pin.half_dup;
	assign push10 = loop_on && link_rise && pin.txen && !pin.rmii; // RL21

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sqe_cnt <= '0;
			col_o <= 1'b0;
			crs_o <= 1'b0;
		end else begin
			crs_o <= pin.speed100 ? crs100 : (loop_on && pin.txen);
			if (loop_on && txen_q && !pin.txen) begin
				sqe_cnt <= SQE_W'(SQE_CYC); // RL21
			end else if (sqe_cnt != '0) begin
				sqe_cnt <= sqe_cnt - 1'b1;
			end
			col_o <= (sqe_cnt != '0); // RL21
		end
	end

	// receive buffer between decoder and MAC interface
	logic buf_in_v;
	logic buf_in_r;
	fepcs_rxw_t buf_in;
	logic buf_out_v;
	logic buf_out_r;
	fepcs_rxw_t buf_out;

	assign buf_in_v = push100 | push10;
	assign buf_in = push100 ? fepcs_rxw_t'({pw100.data, pw100.dv, pw100.er | ovr})
		: fepcs_rxw_t'({pin.txd, 1'b1, 1'b0}); // nib only updates at this edge

	// a word lost to a stalled MAC side is reported on the next 100 Mb word
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ovr <= 1'b0;
		end else if (buf_in_v && !buf_in_r) begin
			ovr <= 1'b1;
		end else if (buf_in_v) begin
			ovr <= 1'b0;
		end
	end

	fepcs_skid #(
		.WIDTH(RXW_W),
		.DEPTH(2)
	) u_rxbuf (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(buf_in_v),
		.in_ready_o(buf_in_r),
		.in_data_i(buf_in),
		.out_valid_o(buf_out_v),
		.out_ready_i(buf_out_r),
		.out_data_o(buf_out)
	);

	// receive clock and MAC side drain
	logic next_rclk;
	logic rclk_fall;
	logic dib_ph;
	logic [1:0] rmii_hi;

	always_comb begin
		next_rclk = rx_clk_o;
		if (pin.signal_detect_flag && pin.speed100) begin
			if (rx_ph == PHASE_LAST || rx_ph == 3'h1) begin
				next_rclk = ~rx_clk_o; // RL16
			end
		end else begin
			next_rclk = ~rx_clk_o; // RL16
		end
	end
	assign rclk_fall = rx_clk_o & ~next_rclk;
	assign buf_out_r = pin.rmii ? (dib_ph == 1'b0) : rclk_fall;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_clk_o <= 1'b0;
			rxd_o <= '0;
			rx_dv_o <= 1'b0;
			rx_er_o <= 1'b0;
			dib_ph <= 1'b0;
			rmii_hi <= '0;
		end else begin
			rx_clk_o <= next_rclk;
			if (pin.rmii) begin
				if (dib_ph) begin
					rxd_o <= {2'h0, rmii_hi}; // RL17
					dib_ph <= 1'b0;
				end else if (buf_out_v) begin
					rxd_o <= {2'h0, buf_out.data[1:0]}; // RL17
					rmii_hi <= buf_out.data[3:2];
					rx_dv_o <= buf_out.dv;
					rx_er_o <= buf_out.er;
					dib_ph <= 1'b1;
				end else begin
					rxd_o <= '0;
					rx_dv_o <= 1'b0;
					rx_er_o <= 1'b0;
				end
			end else if (rclk_fall) begin
				rxd_o <= buf_out_v ? buf_out.data : 4'h0; // RL15
				rx_dv_o <= buf_out_v & buf_out.dv; // RL10 RL11
				rx_er_o <= buf_out_v & buf_out.er;
			end
		end
	end
endmodule : fepcs_mii_path

/* rtl/fepcs_pkg.sv */
// fepcs_pkg: constants, code-groups and carriers for the 100 Mb coding path
// assumes a single 50 MHz core clock; one line bit handled per core cycle
package fepcs_pkg;
	localparam int CLK_MHZ = 50;
	// descrambler idle search window, 500 bytes at 100 Mb
	localparam int IDLE_WINDOW_US = 40;
	localparam int IDLE_WINDOW_CYC = IDLE_WINDOW_US * CLK_MHZ;
	localparam int WIN_W = 12;
	// heartbeat pulse after a 10 Mb transmission
	localparam int SQE_NS = 1000;
	localparam int SQE_CYC = SQE_NS * CLK_MHZ / 1000;
	localparam int SQE_W = 7;
	// matching idle bits before the descrambler key is trusted
	localparam int SYNC_BITS = 30;
	localparam int SYNC_W = 5;
	localparam int LFSR_W = 11;
	localparam int TAP_A = 10;
	localparam int TAP_B = 8;
	localparam logic SEED_TOP = 1'b1;
	localparam logic [4:0] SEED_LOW = 5'h0A;
	localparam logic [2:0] PHASE_LAST = 3'h4;
	localparam logic [1:0] STRAP_CYC = 2'h2;
	localparam logic [4:0] CG_IDLE = 5'h1F;
	localparam logic [4:0] CG_J = 5'h18;
	localparam logic [4:0] CG_K = 5'h11;
	localparam logic [4:0] CG_T = 5'h0D;
	localparam logic [4:0] CG_R = 5'h07;
	localparam logic [4:0] CG_H = 5'h04;
	localparam logic [3:0] NIB_PRE = 4'h5;
	localparam logic [3:0] NIB_BAD_SSD = 4'hE;
	localparam logic [1:0] LVL_ZERO = 2'h0;
	localparam logic [1:0] LVL_POS = 2'h1;
	localparam logic [1:0] LVL_NEG = 2'h3;
	localparam int RXW_W = 6;

	typedef struct packed {
		logic [3:0] data;
		logic dv;
		logic er;
	} fepcs_rxw_t;

	typedef struct packed {
		logic link_clk;
		logic txen;
		logic [3:0] txd;
		logic [1:0] level;
		logic signal_detect_flag;
		logic link_fail;
		logic rmii;
		logic speed100;
		logic half_dup;
		logic [4:0] phy_address_setting;
	} fepcs_pins_t;

	localparam logic [4:0] CODE_TAB [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
		5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};

	function automatic logic [4:0] fepcs_enc5(input logic [3:0] nib);
		return CODE_TAB[nib];
	endfunction : fepcs_enc5

	// returns {valid, nibble}
	function automatic logic [4:0] fepcs_dec5(input logic [4:0] cg);
		logic [4:0] r;
		r = {1'b0, NIB_BAD_SSD};
		for (int i = 0; i < 16; i++) begin
			if (CODE_TAB[i] == cg) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction : fepcs_dec5
endpackage : fepcs_pkg

/* rtl/fepcs_skid.sv */
// fepcs_skid: small valid/ready word buffer
// assumes both sides on the same clock; a full buffer takes a word only while one leaves
`timescale 1ns/100ps
module fepcs_skid #(
	parameter int WIDTH = 6,
	parameter int DEPTH = 2
) (
	input wire logic clk_i, // core clock
	input wire logic rst_n_i, // async reset, low
	input wire logic in_valid_i, // word offered
	output logic in_ready_o, // room for a word
	input wire logic [WIDTH-1:0] in_data_i, // word in
	output logic out_valid_o, // word available
	input wire logic out_ready_i, // drain takes word
	output logic [WIDTH-1:0] out_data_o // word out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic do_wr;
	logic do_rd;

	assign in_ready_o = (count != (AW+1)'(DEPTH)) | out_ready_i;
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];
	assign do_wr = in_valid_i & in_ready_o;
	assign do_rd = out_valid_o & out_ready_i;

	always_ff @(posedge clk_i) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (do_wr) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end
endmodule : fepcs_skid

/* verification/fepcs_mii_path_monitor.sv */
// fepcs_mii_path_monitor: port-level assertions for the coding path
// assumes binding to fepcs_mii_path; sees its ports only
`timescale 1ns/100ps
module fepcs_mii_path_monitor (
	input wire logic ref_clk_i, // core clock
	input wire logic rst_n_i, // async reset, low
	input wire logic link_clk_i, // transmit clock
	input wire logic tx_en_i, // transmit enable
	input wire logic [3:0] txd_i, // transmit data
	input wire logic [1:0] rx_level_i, // line level in
	input wire logic signal_detect_flag_i, // signal present
	input wire logic link_fail_i, // link failure
	input wire logic rmii_mode_i, // rmii select
	input wire logic speed_100_i, // speed select
	input wire logic half_duplex_i, // half duplex
	input wire logic [4:0] phy_address_setting_i, // address strap
	input wire logic [1:0] tx_level_o, // line level out
	input wire logic [3:0] rxd_o, // receive nibble
	input wire logic rx_dv_o, // receive valid
	input wire logic rx_er_o, // receive error
	input wire logic crs_o, // carrier sense
	input wire logic col_o, // heartbeat
	input wire logic rx_clk_o // receive clock
);
	import fepcs_pkg::*;
	logic [7:0] col_len;
	logic [3:0] up;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) col_len <= 8'h00;
		else col_len <= col_o ? col_len + 8'h01 : 8'h00;
	end
	// pins settle through two flops before outputs may be judged
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) up <= 4'h0;
		else if (up != 4'hF) up <= up + 4'h1;
	end
	AST_LVL_LEGAL: assert property (tx_level_o != 2'h2)
		else $error("unused line level driven");
	AST_MLT_STEP: assert property ((tx_level_o != LVL_ZERO) |=>
		(tx_level_o == LVL_ZERO) || $stable(tx_level_o)) else $error("level skipped zero");
	AST_BAD_SSD: assert property ((rx_er_o && !rx_dv_o) |-> (rxd_o == NIB_BAD_SSD))
		else $error("bad start nibble wrong");
	AST_SIGNAL_DETECT_FLAG_DROP: assert property ($fell(signal_detect_flag_i) |-> ##[1:24] !rx_dv_o)
		else $error("valid kept after signal loss");
	AST_ECHO_NO_COL: assert property ((tx_en_i && $past(tx_en_i, 4) && !speed_100_i &&
		half_duplex_i) |-> !col_o) else $error("collision during echo");
	AST_SQE_START: assert property (($fell(tx_en_i) && !speed_100_i && half_duplex_i)
		|-> ##[1:8] col_o) else $error("no heartbeat");
	AST_SQE_LEN: assert property ($fell(col_o) |-> (col_len == SQE_CYC))
		else $error("heartbeat length wrong");
	AST_RXCLK_REF: assert property ((up == 4'hF && !signal_detect_flag_i &&
		!$past(signal_detect_flag_i, 4)) |-> (rx_clk_o != $past(rx_clk_o)))
		else $error("receive clock not from reference");
	AST_RXD_EDGE: assert property ((up == 4'hF && !rmii_mode_i &&
		rxd_o != $past(rxd_o)) |-> $fell(rx_clk_o)) else $error("nibble off falling edge");
	cover property ($rose(rx_dv_o));
	cover property ($rose(col_o));
	cover property (rx_er_o && !rx_dv_o);
endmodule : fepcs_mii_path_monitor
bind fepcs_mii_path fepcs_mii_path_monitor i_mon (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.link_clk_i(link_clk_i), .tx_en_i(tx_en_i), .txd_i(txd_i), .rx_level_i(rx_level_i),
	.signal_detect_flag_i(signal_detect_flag_i), .link_fail_i(link_fail_i),
	.rmii_mode_i(rmii_mode_i), .speed_100_i(speed_100_i), .half_duplex_i(half_duplex_i),
	.phy_address_setting_i(phy_address_setting_i), .tx_level_o(tx_level_o), .rxd_o(rxd_o),
	.rx_dv_o(rx_dv_o), .rx_er_o(rx_er_o), .crs_o(crs_o), .col_o(col_o), .rx_clk_o(rx_clk_o));

/* verification/fepcs_mac_model.sv */
// fepcs_mac_model: controller side of the MII, sends nibbles and logs receive words
// assumes MII mode; its transmit clock stands still outside frames
`timescale 1ns/100ps
module fepcs_mac_model (
	input wire logic rx_clk_i, // receive clock
	input wire logic [3:0] rxd_i, // receive nibble
	input wire logic rx_dv_i, // receive valid
	input wire logic rx_er_i, // receive error
	output logic link_clk_o, // transmit clock
	output logic tx_en_o, // transmit enable
	output logic [3:0] txd_o // transmit nibble
);
	import fepcs_pkg::*;
	fepcs_rxw_t got[$];
	initial begin
		link_clk_o = 1'b0;
		tx_en_o = 1'b0;
		txd_o = 4'h0;
	end
	always @(posedge rx_clk_i) begin
		if (rx_dv_i || rx_er_i) got.push_back({rxd_i, rx_dv_i, rx_er_i});
	end
	// odd offset keeps the link clock out of phase with the core clock
	task automatic send(input logic [3:0] nib[$]);
		#7;
		foreach (nib[i]) begin
			tx_en_o = 1'b1;
			txd_o = nib[i];
			#80 link_clk_o = 1'b1;
			#80 link_clk_o = 1'b0;
		end
		tx_en_o = 1'b0;
		txd_o = 4'h0;
	endtask : send
endmodule : fepcs_mac_model

/* verification/fepcs_mii_path_tb_top.sv */
// fepcs_mii_path_tb_top: directed scenarios for the coding path
// assumes MII mode except in t_rmii; the line side is a scrambled MLT-3 symbol driver here
`timescale 1ns/100ps
module fepcs_mii_path_tb_top;
	import fepcs_pkg::*;
	logic ref_clk_i, rst_n_i, link_clk, tx_en, sig, spd, half, lf, rm;
	logic [3:0] txd, rxd;
	logic [1:0] rx_level, tx_level, ph;
	logic [4:0] phy;
	logic rx_dv, rx_er, crs, col, rx_clk;
	logic [10:0] key = 11'h5A3;
	int error_cnt = 0;
	int samples_checked = 0;
	fepcs_mii_path i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk),
		.tx_en_i(tx_en), .txd_i(txd), .rx_level_i(rx_level), .signal_detect_flag_i(sig),
		.link_fail_i(lf), .rmii_mode_i(rm), .speed_100_i(spd), .half_duplex_i(half),
		.phy_address_setting_i(phy), .tx_level_o(tx_level), .rxd_o(rxd), .rx_dv_o(rx_dv),
		.rx_er_o(rx_er), .crs_o(crs), .col_o(col), .rx_clk_o(rx_clk));
	fepcs_mac_model i_mac (.rx_clk_i(rx_clk), .rxd_i(rxd), .rx_dv_i(rx_dv), .rx_er_i(rx_er),
		.link_clk_o(link_clk), .tx_en_o(tx_en), .txd_o(txd));
	initial begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	task automatic wrap_up;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input bit ok, input string msg);
		samples_checked++;
		if (!ok) begin
			error_cnt++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask : chk
	task automatic rst(input logic [4:0] pa);
		rst_n_i = 1'b0;
		phy = pa;
		repeat (6) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		repeat (5) @(negedge ref_clk_i);
		i_mac.got.delete();
	endtask : rst
	// one line bit per core cycle, scrambled, then MLT-3 stepped 0,+,0,-
	task automatic bit_out(input logic b);
		logic nk;
		nk = key[10] ^ key[8];
		key = {key[9:0], nk};
		if (b ^ nk) ph = ph + 2'h1;
		rx_level = ph[0] ? (ph[1] ? LVL_NEG : LVL_POS) : LVL_ZERO;
		@(negedge ref_clk_i);
	endtask : bit_out
	task automatic cg(input logic [4:0] g);
		for (int i = 4; i >= 0; i--) bit_out(g[i]);
	endtask : cg
	task automatic frame_in(input logic [4:0] g[$]);
		repeat (14) cg(CG_IDLE);
		foreach (g[i]) cg(g[i]);
		repeat (6) cg(CG_IDLE);
	endtask : frame_in
	task automatic grab(input logic [4:0] pa, output logic [79:0] s);
		rst(pa);
		repeat (40) begin
			s = {s[77:0], tx_level};
			@(negedge ref_clk_i);
		end
	endtask : grab
	task automatic t_seed;
		logic [79:0] a, b, c;
		grab(5'h03, a);
		grab(5'h03, b);
		grab(5'h1C, c);
		chk(a === b, "idle line not repeatable");
		chk(a !== c, "scrambler ignores address");
	endtask : t_seed
	task automatic t_rx_frame;
		logic [4:0] g[$];
		g = '{CG_J, CG_K};
		for (int n = 0; n < 16; n++) g.push_back(CODE_TAB[n]);
		g.push_back(CG_T);
		g.push_back(CG_R);
		rst(5'h01);
		frame_in(g);
		chk(i_mac.got.size() == 18, "frame word count");
		chk(crs === 1'b0 && rx_dv === 1'b0, "carrier kept after end");
		for (int i = 0; i < 2; i++) chk(i_mac.got[i] === {NIB_PRE, 2'h2}, "preamble");
		for (int n = 0; n < 16; n++) chk(i_mac.got[n + 2] === {4'(n), 2'h2}, "nibble");
	endtask : t_rx_frame
	task automatic t_bad_ssd;
		rst(5'h01);
		frame_in('{CG_J, CODE_TAB[7], CODE_TAB[7]});
		chk(i_mac.got.size() == 1, "bad start word count");
		chk(i_mac.got[0] === {NIB_BAD_SSD, 2'h1}, "bad start word");
	endtask : t_bad_ssd
	task automatic t_bad_code;
		logic [4:0] bad[2] = '{5'h06, 5'h19};
		int n;
		foreach (bad[b]) begin
			rst(5'h01);
			frame_in('{CG_J, CG_K, CODE_TAB[1], bad[b], CODE_TAB[2], CG_T, CG_R});
			n = 0;
			foreach (i_mac.got[i]) n += (i_mac.got[i] === {i_mac.got[i].data, 2'h3});
			chk(n > 0, "invalid group not flagged");
			chk(i_mac.got[0] === {NIB_PRE, 2'h2}, "preamble before error");
		end
	endtask : t_bad_code
	task automatic t_signal_detect_flag;
		for (int k = 0; k < 2; k++) begin
			rst(5'h01);
			fork
				frame_in('{CG_J, CG_K, CODE_TAB[1], CODE_TAB[2], CODE_TAB[3], CODE_TAB[4],
					CODE_TAB[5], CODE_TAB[6], CODE_TAB[7], CODE_TAB[8], CODE_TAB[9],
					CODE_TAB[10]});
				begin
					repeat (95) @(negedge ref_clk_i);
					if (k == 0) sig = 1'b0;
					else lf = 1'b1;
				end
			join
			chk(i_mac.got.size() < 12 && rx_dv === 1'b0, "frame not cut");
			sig = 1'b1;
			lf = 1'b0;
		end
	endtask : t_signal_detect_flag
	// rmii: each word leaves as low dibit then high dibit
	task automatic t_rmii;
		logic [1:0] d[$];
		rm = 1'b1;
		rst(5'h01);
		fork
			frame_in('{CG_J, CG_K, CODE_TAB[9], CODE_TAB[6], CG_T, CG_R});
			repeat (200) begin
				@(negedge ref_clk_i);
				if (rx_dv === 1'b1) d.push_back(rxd[1:0]);
			end
		join
		rm = 1'b0;
		chk(d.size() == 8, "rmii dibit count");
		chk({d[1], d[0], d[3], d[2]} === {NIB_PRE, NIB_PRE}, "rmii preamble");
		chk({d[5], d[4], d[7], d[6]} === 8'h96, "rmii data");
	endtask : t_rmii
	task automatic t_loop10;
		logic [3:0] nib[$] = '{4'h3, 4'hA, 4'hC, 4'h5};
		int w;
		spd = 1'b0;
		half = 1'b1;
		sig = 1'b0;
		rst(5'h01);
		i_mac.send(nib);
		for (w = 0; w < 20 && col !== 1'b1; w++) @(negedge ref_clk_i);
		if (w == 20) begin
			error_cnt++;
			$display("BAD %0t no heartbeat", $time);
		end else begin
			repeat (80) @(negedge ref_clk_i);
			chk(i_mac.got.size() == 4, "echo length");
			foreach (nib[i]) chk(i_mac.got[i] === {nib[i], 2'h2}, "echo nibble");
		end
	endtask : t_loop10
	initial begin
		rx_level = LVL_ZERO;
		ph = 2'h0;
		sig = 1'b1;
		spd = 1'b1;
		half = 1'b0;
		lf = 1'b0;
		rm = 1'b0;
		t_seed();
		t_rx_frame();
		t_bad_ssd();
		t_bad_code();
		t_signal_detect_flag();
		t_rmii();
		t_loop10();
		wrap_up();
	end
endmodule : fepcs_mii_path_tb_top
